// file: design/ilcf_cycle_timer.sv
/*
 Cycle offset counter of the link. Derives the 24.576 MHz count rate from
 the 200 MHz clock by a fractional accumulator and rolls over either on its
 own count or on a synchronised external cycle event.
 Assumes all inputs are already in the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ilcf_map.svh"

module ilcf_cycle_timer
   import ilcf_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   count_en,
   input  wire logic                   ext_sel,
   input  wire logic                   ext_event,
   input  wire logic                   load,
   input  wire logic [`ILCF_OFS_W-1:0] load_offset,
   output logic      [`ILCF_OFS_W-1:0] offset,
   output logic                        rollover
);
   import ilcf_pkg::*;

   localparam logic [`ILCF_ACC_W-1:0] STEP = `ILCF_ACC_W'(`ILCF_CYC_KHZ);
   localparam logic [`ILCF_ACC_W-1:0] MODV = `ILCF_ACC_W'(`ILCF_SYS_KHZ);
   localparam logic [`ILCF_OFS_W-1:0] LAST = `ILCF_OFS_W'(`ILCF_CYCLE_TICKS - 1);

   ilcf_tmr_t q;
   ilcf_tmr_t next_q;

   // The accumulator ticks 24576 times per 200000 clocks, so the average
   // count rate is exact; single ticks jitter by one system clock.
   always_comb begin
      logic [`ILCF_ACC_W:0] sum;
      logic                 tick;
      sum = {1'b0, q.acc} + {1'b0, STEP};
      tick = 1'b0;
      next_q = q;
      next_q.rollover = 1'b0;
      if (sum >= {1'b0, MODV}) begin
         next_q.acc = `ILCF_ACC_W'(sum - {1'b0, MODV});
         tick = 1'b1;
      end else begin
         next_q.acc = sum[`ILCF_ACC_W-1:0];
      end
      if (load) begin
         next_q.offset = load_offset;
      end else if (count_en) begin
         if (ext_sel) begin
            if (ext_event) begin
               next_q.offset = '0;
               next_q.rollover = 1'b1;
            end else if (tick && q.offset != LAST) begin
               next_q.offset = q.offset + `ILCF_OFS_W'(1);
            end
         end else if (tick) begin
            if (q.offset == LAST) begin
               next_q.offset = '0;
               next_q.rollover = 1'b1;
            end else begin
               next_q.offset = q.offset + `ILCF_OFS_W'(1);
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign offset = q.offset;
   assign rollover = q.rollover;

endmodule

`default_nettype wire

// file: design/ilcf_link_control.sv
/*
 Link control and fairness register bank of a 1394 link layer: the priority
 request limit per fairness interval, the set/clear link flags and the
 receive, cycle timer and sync filter controls that those flags steer.
 Assumes a single 200 MHz clock, a plain register port and that rst_n is
 the global reset. Only ext_cycle_in and fair_interval_start are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ilcf_map.svh"

module ilcf_link_control
   import ilcf_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic [`ILCF_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   input  wire logic                    cycle_overrun_event,
   input  wire logic                    ext_cycle_in,
   input  wire logic                    fair_interval_start,
   input  wire logic                    async_req_pending,
   input  wire logic                    pri_arb_grant,
   output logic                         pri_arb_req,
   input  wire logic                    cycle_start_rcvd,
   input  wire logic [`ILCF_OFS_W-1:0]  cycle_start_offset,
   output logic                         cycle_start_tx,
   output logic      [`ILCF_OFS_W-1:0]  cycle_offset,
   input  wire logic                    async_receive_req_en,
   input  wire logic                    rx_phy_pkt,
   input  wire logic                    rx_selfid_pkt,
   output logic                         store_phy_pkt,
   output logic                         store_selfid_pkt,
   input  wire logic [`ILCF_IR_CTX-1:0] ir_sync_tag_filter_raw,
   output logic      [`ILCF_IR_CTX-1:0] ir_sync_tag_filter,
   output logic                         rollover_source_sel,
   output logic                         root_cycle_generator_en,
   output logic                         cycle_offset_count_en,
   output logic                         accept_phy_packets,
   output logic                         accept_selfid_packets,
   output logic                         sync_filter_force
);
   import ilcf_pkg::*;

   ilcf_top_t     q;
   ilcf_top_t     next_q;
   ilcf_bus_req_t bus;
   logic [31:0]   flag_image;
   logic          ext_event;
   logic          ivl_event;
   logic          tmr_rollover;
   logic          tmr_load;

   // Last offset before the internal wrap; the timer keeps its own copy, the checks below use this one.
   localparam logic [`ILCF_OFS_W-1:0] LAST_OFS = `ILCF_OFS_W'(`ILCF_CYCLE_TICKS - 1);

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Both the set and the clear address return this image.
   always_comb begin
      flag_image = `ILCF_ZERO32;
      flag_image[`ILCF_B_SRC] = q.flags.src;
      flag_image[`ILCF_B_MASTER] = q.flags.master;
      flag_image[`ILCF_B_CTEN] = q.flags.cten;
      flag_image[`ILCF_B_PHYPKT] = q.flags.phypkt;
      flag_image[`ILCF_B_SELFID] = q.flags.selfid;
      flag_image[`ILCF_B_SFLOCK] = q.flags.sflock;
   end

   // Edges are taken from the second synchroniser stage only.
   assign ext_event = q.ext_s2 & ~q.ext_prev;
   assign ivl_event = q.ivl_s2 & ~q.ivl_prev;

   // A received cycle start only steers the timer when another node is root.
   assign tmr_load = cycle_start_rcvd & ~q.flags.master;

   ilcf_cycle_timer ilcf_cycle_timer_inst (
      .clock       (clock),
      .rst_n       (rst_n),
      .count_en    (q.flags.cten),
      .ext_sel     (q.flags.src),
      .ext_event   (ext_event),
      .load        (tmr_load),
      .load_offset (cycle_start_offset),
      .offset      (cycle_offset),
      .rollover    (tmr_rollover)
   );

   always_comb begin
      next_q = q;
      next_q.ext_s1 = ext_cycle_in;
      next_q.ext_s2 = q.ext_s1;
      next_q.ext_prev = q.ext_s2;
      next_q.ivl_s1 = fair_interval_start;
      next_q.ivl_s2 = q.ivl_s1;
      next_q.ivl_prev = q.ivl_s2;

      next_q.rdata = `ILCF_ZERO32;
      if (bus.rd) begin
         case (bus.addr)
            `ILCF_ADDR_FAIR: begin
               next_q.rdata = {24'h00_0000, q.fair_limit};
            end
            `ILCF_ADDR_SET, `ILCF_ADDR_CLR: begin
               next_q.rdata = flag_image;
            end
            default: begin
               next_q.rdata = `ILCF_ZERO32;
            end
         endcase
      end

      if (bus.wr) begin
         case (bus.addr)
            `ILCF_ADDR_FAIR: begin
               next_q.fair_limit = bus.wdata[`ILCF_FAIR_W-1:0];
            end
            `ILCF_ADDR_SET: begin
               next_q.flags.src = q.flags.src | bus.wdata[`ILCF_B_SRC];
               next_q.flags.cten = q.flags.cten | bus.wdata[`ILCF_B_CTEN];
               next_q.flags.phypkt = q.flags.phypkt | bus.wdata[`ILCF_B_PHYPKT];
               next_q.flags.selfid = q.flags.selfid | bus.wdata[`ILCF_B_SELFID];
               next_q.flags.sflock = q.flags.sflock | bus.wdata[`ILCF_B_SFLOCK];
               if (!cycle_overrun_event) begin
                  next_q.flags.master = q.flags.master | bus.wdata[`ILCF_B_MASTER];
               end
            end
            `ILCF_ADDR_CLR: begin
               next_q.flags.src = q.flags.src & ~bus.wdata[`ILCF_B_SRC];
               next_q.flags.master = q.flags.master & ~bus.wdata[`ILCF_B_MASTER];
               next_q.flags.cten = q.flags.cten & ~bus.wdata[`ILCF_B_CTEN];
               next_q.flags.phypkt = q.flags.phypkt & ~bus.wdata[`ILCF_B_PHYPKT];
               next_q.flags.selfid = q.flags.selfid & ~bus.wdata[`ILCF_B_SELFID];
               // The lock flag ignores the clear address.
            end
            default: begin
            end
         endcase
      end

      // The hardware clear comes last, so a set in the same cycle cannot race it.
      if (cycle_overrun_event) begin
         next_q.flags.master = 1'b0;
      end

      // A request stays up until granted; a new interval restarts the count.
      if (ivl_event) begin
         next_q.fair_count = '0;
      end
      if (q.pri_req) begin
         if (pri_arb_grant) begin
            next_q.pri_req = 1'b0;
         end
      end else if (async_req_pending && !ivl_event && q.fair_count < q.fair_limit) begin
         next_q.pri_req = 1'b1;
         next_q.fair_count = q.fair_count + `ILCF_FAIR_W'(1);
      end

      // The cycle start trails the wrap by one cycle and uses the flag of that cycle.
      next_q.cs_tx = tmr_rollover & q.flags.master;
      next_q.store_phy = rx_phy_pkt & q.flags.phypkt & async_receive_req_en;
      next_q.store_selfid = rx_selfid_pkt & q.flags.selfid;
      next_q.ir_filt = ir_sync_tag_filter_raw | {`ILCF_IR_CTX{q.flags.sflock}};
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign reg_rdata = q.rdata;
   assign pri_arb_req = q.pri_req;
   assign cycle_start_tx = q.cs_tx;
   assign store_phy_pkt = q.store_phy;
   assign store_selfid_pkt = q.store_selfid;
   assign ir_sync_tag_filter = q.ir_filt;
   assign rollover_source_sel = q.flags.src;
   assign root_cycle_generator_en = q.flags.master;
   assign cycle_offset_count_en = q.flags.cten;
   assign accept_phy_packets = q.flags.phypkt;
   assign accept_selfid_packets = q.flags.selfid;
   assign sync_filter_force = q.flags.sflock;

   // Every output is registered, so checks look one cycle after the cause.
   default clocking dcb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   AST_FAIR_LIMIT: assert property (
      $rose(pri_arb_req) |-> $past(q.fair_count) < $past(q.fair_limit))
      else $error("Priority request issued beyond the fairness limit.");

   AST_FAIR_RSVD: assert property (
      reg_rd && reg_addr == `ILCF_ADDR_FAIR |=> reg_rdata[31:8] == 24'h00_0000)
      else $error("Fairness register reserved bits read non-zero.");

   AST_FLAG_VIEW: assert property (
      reg_rd && (reg_addr == `ILCF_ADDR_SET || reg_addr == `ILCF_ADDR_CLR)
      |=> reg_rdata[`ILCF_B_SRC] == $past(rollover_source_sel)
          && reg_rdata[`ILCF_B_MASTER] == $past(root_cycle_generator_en)
          && reg_rdata[`ILCF_B_CTEN] == $past(cycle_offset_count_en)
          && reg_rdata[`ILCF_B_PHYPKT] == $past(accept_phy_packets)
          && reg_rdata[`ILCF_B_SELFID] == $past(accept_selfid_packets)
          && reg_rdata[`ILCF_B_SFLOCK] == $past(sync_filter_force))
      else $error("Set or clear address did not return the flags.");

   AST_RSVD_FLAGS: assert property (
      reg_rd && (reg_addr == `ILCF_ADDR_SET || reg_addr == `ILCF_ADDR_CLR)
      |=> reg_rdata[31:23] == 9'h000 && reg_rdata[19:11] == 9'h000
          && reg_rdata[8:7] == 2'h0 && reg_rdata[5:0] == 6'h00)
      else $error("Reserved link flag bits read non-zero.");

   AST_SET_ONE: assert property (
      reg_wr && reg_addr == `ILCF_ADDR_SET && reg_wdata[`ILCF_B_CTEN] |=> cycle_offset_count_en)
      else $error("Set write did not set the count enable flag.");

   AST_CLR_ONE: assert property (
      reg_wr && reg_addr == `ILCF_ADDR_CLR && reg_wdata[`ILCF_B_SELFID]
      |=> !accept_selfid_packets)
      else $error("Clear write did not clear the self-ID flag.");

   AST_MASTER_OVR: assert property (
      cycle_overrun_event |=> !root_cycle_generator_en)
      else $error("Cycle master flag survived a cycle overrun.");

   AST_MASTER_BLOCK: assert property (
      reg_wr && reg_addr == `ILCF_ADDR_SET && reg_wdata[`ILCF_B_MASTER]
      && cycle_overrun_event && !root_cycle_generator_en |=> !root_cycle_generator_en)
      else $error("Cycle master flag set while overrun pending.");

   AST_CS_TX: assert property (
      tmr_rollover && root_cycle_generator_en |=> cycle_start_tx)
      else $error("No cycle start sent at rollover as master.");

   AST_OFS_HOLD: assert property (
      !cycle_offset_count_en && !tmr_load |=> $stable(cycle_offset))
      else $error("Cycle offset moved while counting disabled.");

   AST_LOCK_STICK: assert property (
      sync_filter_force |=> sync_filter_force [*2])
      else $error("Sync filter lock cleared without reset.");

   AST_FORCE_ONES: assert property (
      sync_filter_force |=> &ir_sync_tag_filter)
      else $error("Sync filter bit not forced to one.");

   AST_PHY_GATE: assert property (
      rx_phy_pkt && !(accept_phy_packets && async_receive_req_en) |=> !store_phy_pkt)
      else $error("PHY packet stored while not accepted.");

   AST_SELFID_GATE: assert property (
      rx_selfid_pkt && !accept_selfid_packets |=> !store_selfid_pkt)
      else $error("Self-ID packet accepted while disabled.");

   AST_LOAD_SYNC: assert property (
      cycle_start_rcvd && !root_cycle_generator_en |=> cycle_offset == $past(cycle_start_offset))
      else $error("Received cycle start did not load the offset.");

   AST_WRAP_INT: assert property (
      !rollover_source_sel && cycle_offset_count_en && !tmr_load && cycle_offset == LAST_OFS
      |=> (tmr_rollover && cycle_offset == '0)
          || (!tmr_rollover && cycle_offset == LAST_OFS))
      else $error("Internal rollover not at the last offset.");

   AST_EXT_ROLL: assert property (
      rollover_source_sel && cycle_offset_count_en && ext_event && !tmr_load
      |=> tmr_rollover && cycle_offset == '0)
      else $error("External cycle event did not roll the timer over.");

   // Covers mark the main scenarios that the bench is expected to reach.

   COV_MASTER_TX: cover property (root_cycle_generator_en ##1 cycle_start_tx);
   COV_FAIR_FULL: cover property (async_req_pending && q.fair_count == q.fair_limit
                                  && q.fair_limit != `ILCF_FAIR_RST);
   COV_EXT_ROLL: cover property (rollover_source_sel && ext_event && cycle_offset_count_en);
   COV_OVR_CLR: cover property (root_cycle_generator_en ##1 cycle_overrun_event);
   COV_PEER_LOAD: cover property (cycle_start_rcvd && !root_cycle_generator_en);

endmodule

`default_nettype wire

// file: design/ilcf_map.svh
/*
 Register offsets, flag positions, reset values and timing counts of the
 link control and fairness block. Included by the package and by every
 design file that reads the constants; the guard keeps one copy.
*/
`ifndef ILCF_MAP_SVH
`define ILCF_MAP_SVH

`define ILCF_ADDR_W        8
`define ILCF_ADDR_FAIR     8'hDC
`define ILCF_ADDR_SET      8'hE0
`define ILCF_ADDR_CLR      8'hE4

`define ILCF_B_SRC         22
`define ILCF_B_MASTER      21
`define ILCF_B_CTEN        20
`define ILCF_B_PHYPKT      10
`define ILCF_B_SELFID      9
`define ILCF_B_SFLOCK      6

`define ILCF_FAIR_W        8
`define ILCF_FAIR_RST      8'h00
`define ILCF_ZERO32        32'h0000_0000
`define ILCF_IR_CTX        4

`define ILCF_SYS_KHZ       200000
`define ILCF_CYC_KHZ       24576
`define ILCF_CYCLE_US      125
`define ILCF_CYCLE_TICKS   ((`ILCF_CYCLE_US * `ILCF_CYC_KHZ) / 1000)
`define ILCF_OFS_W         12
`define ILCF_ACC_W         18

`endif

// file: design/ilcf_pkg.sv
/*
 Types shared by the link control block and its cycle timer.
 Assumes the constant header is on the include path.
*/
`include "ilcf_map.svh"

package ilcf_pkg;

   typedef struct packed {
      logic src;
      logic master;
      logic cten;
      logic phypkt;
      logic selfid;
      logic sflock;
   } ilcf_flags_t;

   typedef struct packed {
      logic [`ILCF_ADDR_W-1:0] addr;
      logic [31:0]             wdata;
      logic                    wr;
      logic                    rd;
   } ilcf_bus_req_t;

   typedef struct packed {
      logic [`ILCF_ACC_W-1:0] acc;
      logic [`ILCF_OFS_W-1:0] offset;
      logic                   rollover;
   } ilcf_tmr_t;

   typedef struct packed {
      ilcf_flags_t               flags;
      logic [`ILCF_FAIR_W-1:0]   fair_limit;
      logic [`ILCF_FAIR_W-1:0]   fair_count;
      logic                      pri_req;
      logic [31:0]               rdata;
      logic                      ext_s1;
      logic                      ext_s2;
      logic                      ext_prev;
      logic                      ivl_s1;
      logic                      ivl_s2;
      logic                      ivl_prev;
      logic                      store_phy;
      logic                      store_selfid;
      logic                      cs_tx;
      logic [`ILCF_IR_CTX-1:0]   ir_filt;
   } ilcf_top_t;

endpackage

// file: test/ilcf_phy_model.sv
/*
 Behavioural PHY arbiter that answers the priority request of the link.
 Assumes the link holds its request until it has seen one grant pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module ilcf_phy_model (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        pri_arb_req,
   input  wire logic [3:0]  grant_delay,
   output logic             pri_arb_grant,
   output logic      [15:0] req_count
);
   logic [3:0] wait_cnt;
   logic       busy;

   // One grant per request; busy blocks a second grant while the request falls.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pri_arb_grant <= 1'b0;
         req_count     <= 16'h0000;
         wait_cnt      <= 4'h0;
         busy          <= 1'b0;
      end else begin
         pri_arb_grant <= 1'b0;
         if (pri_arb_req && !busy) begin
            if (wait_cnt == grant_delay) begin
               pri_arb_grant <= 1'b1;
               busy          <= 1'b1;
               req_count     <= req_count + 16'h0001;
               wait_cnt      <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else if (!pri_arb_req) begin
            busy <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// file: test/tb_ieee1394_link_control_fairness.sv
/*
 Self-checking bench of the link control and fairness block with a PHY model.
 Assumes the design package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_ieee1394_link_control_fairness;
   import ilcf_pkg::*;
   localparam int PERIOD = 3072 * 200000 / 24576;
   logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
   logic ovr = 1'b0, ext = 1'b0, fis = 1'b0, pend = 1'b0, grant, req;
   logic csr = 1'b0, ar_en = 1'b0, rphy = 1'b0, rsid = 1'b0, sphy, ssid;
   logic [11:0] cso = 12'h000, ofs, held;
   logic cs_tx, f_src, f_mst, f_cten, f_phy, f_sid, f_lock;
   logic [3:0] raw = 4'h5, filt;
   logic [15:0] reqs;
   int err_total = 0, cmp_count = 0, cyc = 0, n;

   always #2.5 clock = ~clock;

   ilcf_link_control ilcf_link_control_inst (
      .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cycle_overrun_event(ovr), .ext_cycle_in(ext), .fair_interval_start(fis),
      .async_req_pending(pend), .pri_arb_grant(grant), .pri_arb_req(req),
      .cycle_start_rcvd(csr), .cycle_start_offset(cso), .cycle_start_tx(cs_tx),
      .cycle_offset(ofs), .async_receive_req_en(ar_en), .rx_phy_pkt(rphy),
      .rx_selfid_pkt(rsid), .store_phy_pkt(sphy), .store_selfid_pkt(ssid),
      .ir_sync_tag_filter_raw(raw), .ir_sync_tag_filter(filt),
      .rollover_source_sel(f_src), .root_cycle_generator_en(f_mst),
      .cycle_offset_count_en(f_cten), .accept_phy_packets(f_phy),
      .accept_selfid_packets(f_sid), .sync_filter_force(f_lock));

   ilcf_phy_model ilcf_phy_model_inst (
      .clock(clock), .rst_n(rst_n), .pri_arb_req(req), .grant_delay(4'h2),
      .pri_arb_grant(grant), .req_count(reqs));

   task automatic close_out();
      $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_total = err_total + 1;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the read edge.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic do_reset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
   endtask

   task automatic wait_tx(input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clock);
         #1 cnt++;
      end while (cs_tx !== 1'b1 && cnt < lim);
   endtask

   task automatic t_regs();
      rd(8'hDC, rv); chk(rv, 32'h0);
      rd(8'hE0, rv); chk(rv, 32'h0);
      wr(8'hDC, 32'hFFFF_FFFF); rd(8'hDC, rv); chk(rv, 32'h0000_00FF);
      wr(8'hE8, 32'hFFFF_FFFF); rd(8'hE8, rv); chk(rv, 32'h0);
      wr(8'hE0, 32'hFFFF_FFBF); rd(8'hE4, rv); chk(rv, 32'h0070_0600);
      #1 chk({f_src, f_mst, f_cten, f_phy, f_sid, f_lock}, 32'h3E);
      wr(8'hE4, 32'h0040_0200); rd(8'hE0, rv); chk(rv, 32'h0030_0400);
      wr(8'hE0, 32'h0); wr(8'hE4, 32'h0); rd(8'hE4, rv); chk(rv, 32'h0030_0400);
      wr(8'hE4, 32'hFFFF_FFBF); rd(8'hE0, rv); chk(rv, 32'h0);
   endtask

   task automatic t_fair();
      wr(8'hDC, 32'h0000_0003);
      @(posedge clock) pend <= 1'b1;
      repeat (100) @(posedge clock);
      chk(reqs, 32'h3);
      fis <= 1'b1;
      repeat (6) @(posedge clock);
      fis <= 1'b0;
      repeat (100) @(posedge clock);
      chk(reqs, 32'h6);
      pend <= 1'b0;
   endtask

   task automatic t_overrun();
      wr(8'hE0, 32'h0020_0000);
      #1 chk(f_mst, 32'h1);
      @(posedge clock) ovr <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(f_mst, 32'h0);
      wr(8'hE0, 32'h0020_0000);
      repeat (2) @(posedge clock);
      rd(8'hE0, rv); chk(rv, 32'h0);
      @(posedge clock) ovr <= 1'b0;
      wr(8'hE0, 32'h0020_0000); rd(8'hE0, rv); chk(rv, 32'h0020_0000);
   endtask

   task automatic t_timer();
      wr(8'hE0, 32'h0030_0000);
      wait_tx(PERIOD + 10, n);
      wait_tx(PERIOD + 10, n);
      chk(32'(n >= PERIOD - 1 && n <= PERIOD + 1), 32'h1);
      wr(8'hE0, 32'h0040_0000);
      repeat (20) @(posedge clock);
      @(posedge clock) ext <= 1'b1;
      wait_tx(12, n);
      chk(32'(n < 12 && ofs < 12'h004), 32'h1);
      @(posedge clock) ext <= 1'b0;
      wr(8'hE4, 32'h0010_0000);
      #1 held = ofs;
      repeat (200) @(posedge clock);
      #1 chk(ofs, held);
      wr(8'hE4, 32'h0060_0000); wr(8'hE0, 32'h0010_0000);
      @(posedge clock);
      csr <= 1'b1; cso <= 12'h123;
      @(posedge clock) csr <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk(32'(ofs >= 12'h123 && ofs <= 12'h124), 32'h1);
   endtask

   task automatic rx_pulse(input logic en, output logic [1:0] got);
      @(posedge clock);
      ar_en <= en; rphy <= 1'b1; rsid <= 1'b1;
      @(posedge clock);
      rphy <= 1'b0; rsid <= 1'b0;
      #1 got = {sphy, ssid};
   endtask

   task automatic t_rx();
      logic [1:0] g;
      // Self-ID buffer address is assumed loaded before reception is enabled.
      wr(8'hE0, 32'h0000_0600);
      rx_pulse(1'b1, g); chk(g, 32'h3);
      rx_pulse(1'b0, g); chk(g, 32'h1);
      wr(8'hE4, 32'h0000_0200);
      rx_pulse(1'b1, g); chk(g, 32'h2);
      wr(8'hE4, 32'h0000_0400);
      rx_pulse(1'b1, g); chk(g, 32'h0);
   endtask

   task automatic t_lock();
      #1 chk(filt, 32'h5);
      wr(8'hE0, 32'h0000_0040);
      repeat (2) @(posedge clock);
      #1 chk(filt, 32'hF);
      wr(8'hE4, 32'h0000_0040); rd(8'hE0, rv); chk(rv, 32'h0020_0040);
      do_reset();
      repeat (2) @(posedge clock);
      #1 chk({f_lock, filt}, 32'h05);
   endtask

   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_regs();
      t_fair();
      t_overrun();
      t_rx();
      t_lock();
      t_timer();
      close_out();
   end
endmodule

`default_nettype wire
